//--- rtl/rss_file_mem.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// File register memory
// ****************************************
module rss_file_mem #(
    parameter int DEPTH = 128,
    parameter int AW = 7,
    parameter int DW = 8
) (
    // Clock
    input wire logic clock,
    // Write port
    input wire logic writeEnable,
    input wire logic [AW-1:0] writeAddr,
    input wire logic [DW-1:0] writeData,
    // Read port, data one cycle after the request
    input wire logic readEnable,
    input wire logic [AW-1:0] readAddr,
    output logic [DW-1:0] readData
);
    logic [DW-1:0] mem [DEPTH];

    // Storage write
    always_ff @(posedge clock)
    begin
        if (writeEnable)
        begin
            mem[writeAddr] <= writeData;
        end
    end

    // Registered read
    always_ff @(posedge clock)
    begin
        if (readEnable)
        begin
            readData <= mem[readAddr];
        end
    end
endmodule // rss_file_mem

`default_nettype wire

//--- rtl/rss_exec_unit.sv
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Shared constants
// ****************************************
package rss_pkg;
    localparam logic [11:0] CMD_OFS = 12'h000;
    localparam logic [11:0] ACC_OFS = 12'h004;
    localparam logic [11:0] STAT_OFS = 12'h008;
    localparam logic [11:0] WDOG_OFS = 12'h00c;
    localparam logic [2:0] FILE_REGION = 3'h1;
    localparam logic [2:0] OP_ROTL = 3'h1;
    localparam logic [2:0] OP_ROTR = 3'h2;
    localparam logic [2:0] OP_SUB = 3'h3;
    localparam logic [2:0] OP_SLEEP = 3'h4;
    localparam logic [2:0] OP_WAKE = 3'h5;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST_BIT = 3;
    localparam int CMD_ADDR_LSB = 4;
    localparam int CMD_LIT_LSB = 16;
    localparam int STAT_C = 0;
    localparam int STAT_DC = 1;
    localparam int STAT_Z = 2;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] WDOG_CLEAR = 8'h00;
    localparam logic [7:0] WDOG_LAST = 8'hff;
    localparam logic [15:0] PRESCALE_DEFAULT = 16'h0010;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} rss_state_t;
endpackage

// ****************************************
// Execution unit
// ****************************************
module rss_exec_unit #(
    parameter logic [15:0] PRESCALE = rss_pkg::PRESCALE_DEFAULT
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // AXI4-Lite write
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Power state
    output logic sleeping,
    output logic oscRun
);
    rss_pkg::rss_state_t state;
    logic [2:0] opCode;
    logic dest;
    logic [6:0] fileAddr;
    logic [7:0] literal;
    logic [7:0] acc;
    logic carry, nibbleFlag, zeroFlag, expiryStatus, powerDownStatus;
    logic [7:0] watchdogCounter;
    logic [15:0] prescaler;
    logic rdPend;
    logic memWe, memRe;
    logic [6:0] memWaddr, memRaddr;
    logic [7:0] memWdata, memRdata;
    logic wrFire, wrFile, wrMapped, wrRaise, rdFire, rdFile, rdRaise, cmdWrite;
    logic execOn, isRot, rotCarry, subCarry, subNibble, subZero, tick;
    logic [7:0] rotResult, subResult;
    logic [31:0] regRead;

    // ****************************************
    // Decode and datapath
    // ****************************************
    always_comb
    begin
        wrFire = s_axi_awvalid && s_axi_awready;
        wrFile = s_axi_awaddr[11:9] == rss_pkg::FILE_REGION;
        wrMapped = wrFile || s_axi_awaddr == rss_pkg::CMD_OFS || s_axi_awaddr == rss_pkg::ACC_OFS
            || s_axi_awaddr == rss_pkg::STAT_OFS || s_axi_awaddr == rss_pkg::WDOG_OFS;
        wrRaise = state == rss_pkg::ST_IDLE && s_axi_awvalid && s_axi_wvalid && !s_axi_awready
            && !s_axi_bvalid && !s_axi_arready && !rdPend && !s_axi_rvalid;
        rdFire = s_axi_arvalid && s_axi_arready;
        rdFile = s_axi_araddr[11:9] == rss_pkg::FILE_REGION;
        rdRaise = state == rss_pkg::ST_IDLE && s_axi_arvalid && !s_axi_arready && !rdPend
            && !s_axi_rvalid && !s_axi_awready && !s_axi_bvalid
            && !(s_axi_awvalid && s_axi_wvalid);
        cmdWrite = wrFire && s_axi_awaddr == rss_pkg::CMD_OFS && s_axi_wstrb[0];
        execOn = state == rss_pkg::ST_EXEC;
        isRot = opCode == rss_pkg::OP_ROTL || opCode == rss_pkg::OP_ROTR;
        // Rotate through carry
        if (opCode == rss_pkg::OP_ROTL)
        begin
            rotResult = {memRdata[6:0], carry};
            rotCarry = memRdata[7];
        end
        else
        begin
            rotResult = {carry, memRdata[7:1]};
            rotCarry = memRdata[0];
        end
        // Literal minus accumulator
        subResult = literal - acc;
        subCarry = acc <= literal;
        subNibble = acc[3:0] <= literal[3:0];
        subZero = subResult == 8'h00;
        tick = prescaler == PRESCALE - 16'h0001;
        // File port: rotate write back or bus access
        memWe = (execOn && isRot && dest) || (wrFire && wrFile && s_axi_wstrb[0]);
        memWaddr = (execOn && isRot) ? fileAddr : s_axi_awaddr[8:2];
        memWdata = (execOn && isRot) ? rotResult : s_axi_wdata[7:0];
        memRe = state == rss_pkg::ST_FETCH || (rdFire && rdFile);
        memRaddr = state == rss_pkg::ST_FETCH ? fileAddr : s_axi_araddr[8:2];
        // Register read mux
        unique case (s_axi_araddr)
            rss_pkg::CMD_OFS: regRead = {8'h00, literal, 5'h00, fileAddr, dest, opCode};
            rss_pkg::ACC_OFS: regRead = {24'h000000, acc};
            rss_pkg::STAT_OFS: regRead = {25'h0000000, sleeping, state != rss_pkg::ST_IDLE,
                expiryStatus, powerDownStatus, zeroFlag, nibbleFlag, carry};
            rss_pkg::WDOG_OFS: regRead = {24'h000000, watchdogCounter};
            default: regRead = 32'h00000000;
        endcase
    end

    // ****************************************
    // Bus slave
    // ****************************************
    // Write channels, taken together, one response
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rss_pkg::RESP_OKAY;
        end
        else
        begin
            if (wrFire)
            begin
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrMapped ? rss_pkg::RESP_OKAY : rss_pkg::RESP_SLVERR;
            end
            else if (wrRaise)
            begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel, file reads take one extra cycle
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= rss_pkg::RESP_OKAY;
            rdPend <= 1'b0;
        end
        else
        begin
            if (rdFire)
            begin
                s_axi_arready <= 1'b0;
                rdPend <= rdFile;
                s_axi_rvalid <= !rdFile;
                s_axi_rdata <= regRead;
                s_axi_rresp <= (rdFile || regRead != 32'h00000000 || s_axi_araddr[11:4] == 8'h00)
                    ? rss_pkg::RESP_OKAY : rss_pkg::RESP_SLVERR;
            end
            else if (rdRaise)
            begin
                s_axi_arready <= 1'b1;
            end
            if (rdPend)
            begin
                rdPend <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, memRdata};
                s_axi_rresp <= rss_pkg::RESP_OKAY;
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Sequencer and operand latch
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state <= rss_pkg::ST_IDLE;
            opCode <= 3'h0;
            dest <= 1'b0;
            fileAddr <= 7'h00;
            literal <= 8'h00;
        end
        else
        begin
            unique case (state)
                rss_pkg::ST_IDLE:
                begin
                    if (cmdWrite)
                    begin
                        opCode <= s_axi_wdata[rss_pkg::CMD_OP_LSB +: 3];
                        dest <= s_axi_wdata[rss_pkg::CMD_DEST_BIT];
                        fileAddr <= s_axi_wdata[rss_pkg::CMD_ADDR_LSB +: 7];
                        literal <= s_axi_wdata[rss_pkg::CMD_LIT_LSB +: 8];
                        if (!sleeping && s_axi_wdata[2:0] >= rss_pkg::OP_ROTL
                            && s_axi_wdata[2:0] <= rss_pkg::OP_SLEEP)
                        begin
                            state <= rss_pkg::ST_FETCH;
                        end
                    end
                end
                rss_pkg::ST_FETCH: state <= rss_pkg::ST_EXEC;
                rss_pkg::ST_EXEC: state <= rss_pkg::ST_IDLE;
            endcase
        end
    end

    // Accumulator
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            acc <= rss_pkg::ACC_RESET;
        end
        else if (execOn && isRot && !dest)
        begin
            acc <= rotResult;
        end
        else if (execOn && opCode == rss_pkg::OP_SUB)
        begin
            acc <= subResult;
        end
        else if (wrFire && s_axi_awaddr == rss_pkg::ACC_OFS && s_axi_wstrb[0])
        begin
            acc <= s_axi_wdata[7:0];
        end
    end

    // Arithmetic flags
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            carry <= 1'b0;
            nibbleFlag <= 1'b0;
            zeroFlag <= 1'b0;
        end
        else if (execOn && isRot)
        begin
            carry <= rotCarry;
        end
        else if (execOn && opCode == rss_pkg::OP_SUB)
        begin
            carry <= subCarry;
            nibbleFlag <= subNibble;
            zeroFlag <= subZero;
        end
        else if (wrFire && s_axi_awaddr == rss_pkg::STAT_OFS && s_axi_wstrb[0])
        begin
            carry <= s_axi_wdata[rss_pkg::STAT_C];
            nibbleFlag <= s_axi_wdata[rss_pkg::STAT_DC];
            zeroFlag <= s_axi_wdata[rss_pkg::STAT_Z];
        end
    end

    // ****************************************
    // Watchdog and power down
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            watchdogCounter <= rss_pkg::WDOG_CLEAR;
            prescaler <= 16'h0000;
            expiryStatus <= 1'b1;
            powerDownStatus <= 1'b1;
            sleeping <= 1'b0;
            oscRun <= 1'b1;
        end
        else if (execOn && opCode == rss_pkg::OP_SLEEP)
        begin
            watchdogCounter <= rss_pkg::WDOG_CLEAR;
            prescaler <= 16'h0000;
            expiryStatus <= 1'b1;
            powerDownStatus <= 1'b0;
            sleeping <= 1'b1;
            oscRun <= 1'b0;
        end
        else
        begin
            prescaler <= tick ? 16'h0000 : prescaler + 16'h0001;
            if (tick)
            begin
                watchdogCounter <= watchdogCounter + 8'h01;
            end
            // Timeout or wake command leaves sleep
            if (tick && watchdogCounter == rss_pkg::WDOG_LAST)
            begin
                expiryStatus <= 1'b0;
                sleeping <= 1'b0;
                oscRun <= 1'b1;
            end
            else if (cmdWrite && s_axi_wdata[2:0] == rss_pkg::OP_WAKE)
            begin
                sleeping <= 1'b0;
                oscRun <= 1'b1;
            end
        end
    end

    rss_file_mem #(.DEPTH(128), .AW(7), .DW(8)) fileMem (
        .clock(clock),
        .writeEnable(memWe),
        .writeAddr(memWaddr),
        .writeData(memWdata),
        .readEnable(memRe),
        .readAddr(memRaddr),
        .readData(memRdata)
    );

    // ****************************************
    // Checks
    // ****************************************
    rotl_carry_a: assert property (@(posedge clock) disable iff (!rst_n)
        execOn && opCode == rss_pkg::OP_ROTL |=> carry == $past(memRdata[7])
            && ($past(dest) || acc == {$past(memRdata[6:0]), $past(carry)}))
        else $error("rotate left wrong");
    rotr_carry_a: assert property (@(posedge clock) disable iff (!rst_n)
        execOn && opCode == rss_pkg::OP_ROTR |=> carry == $past(memRdata[0])
            && ($past(dest) || acc == {$past(carry), $past(memRdata[7:1])}))
        else $error("rotate right wrong");
    dest_acc_a: assert property (@(posedge clock) disable iff (!rst_n)
        execOn && isRot && !dest |-> !memWe ##1 acc == $past(rotResult))
        else $error("rotate to accumulator wrong");
    dest_file_a: assert property (@(posedge clock) disable iff (!rst_n)
        execOn && isRot && dest |-> memWe && memWaddr == fileAddr ##1 $stable(acc))
        else $error("rotate to file wrong");
    rot_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
        execOn && isRot |=> $stable(zeroFlag) && $stable(nibbleFlag))
        else $error("rotate touched other flags");
    sleep_wdog_a: assert property (@(posedge clock) disable iff (!rst_n)
        execOn && opCode == rss_pkg::OP_SLEEP |=> watchdogCounter == 8'h00
            && prescaler == 16'h0000)
        else $error("watchdog not cleared");
    sleep_status_a: assert property (@(posedge clock) disable iff (!rst_n)
        execOn && opCode == rss_pkg::OP_SLEEP |=> expiryStatus && !powerDownStatus)
        else $error("status bits wrong after sleep");
    sleep_osc_a: assert property (@(posedge clock) disable iff (!rst_n)
        cmdWrite && !sleeping && s_axi_wdata[2:0] == rss_pkg::OP_SLEEP
            |-> ##3 sleeping && !oscRun)
        else $error("sleep not entered");
    sub_result_a: assert property (@(posedge clock) disable iff (!rst_n)
        execOn && opCode == rss_pkg::OP_SUB |=> acc == $past(literal) - $past(acc))
        else $error("subtract result wrong");
    sub_carry_a: assert property (@(posedge clock) disable iff (!rst_n)
        execOn && opCode == rss_pkg::OP_SUB |=> carry == ($past(acc) <= $past(literal))
            && nibbleFlag == ($past(acc[3:0]) <= $past(literal[3:0])))
        else $error("subtract carry wrong");
    sub_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
        execOn && opCode == rss_pkg::OP_SUB |=> zeroFlag == (acc == 8'h00))
        else $error("subtract zero flag wrong");
endmodule // rss_exec_unit

`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Self-checking bench for the execution unit
// ****************************************
module tb;
    // One table row: operands in, results out
    typedef struct packed {
        logic [2:0] op;
        logic dest;
        logic [6:0] fa;
        logic [7:0] fileIn;
        logic [7:0] accIn;
        logic [2:0] flagIn;
        logic [7:0] lit;
        logic [7:0] accOut;
        logic [7:0] fileOut;
        logic [2:0] flagOut;
    } rss_row_t;
    localparam int TIMEOUT = 20000;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic sleeping;
    logic oscRun;
    int errorCnt = 0;
    int checksDone = 0;
    int cycles = 0;
    logic [31:0] d;
    logic [1:0] resp;
    rss_row_t r;
    // Flags are C, nibble, zero in bits 0..2
    rss_row_t rows [9] = '{
        '{rss_pkg::OP_ROTL, 1'b0, 7'h05, 8'he6, 8'h00, 3'h0, 8'h00, 8'hcc, 8'he6, 3'h1},
        '{rss_pkg::OP_ROTL, 1'b1, 7'h7f, 8'h80, 8'h55, 3'h2, 8'h00, 8'h55, 8'h00, 3'h3},
        '{rss_pkg::OP_ROTR, 1'b0, 7'h00, 8'h01, 8'h33, 3'h5, 8'h00, 8'h80, 8'h01, 3'h5},
        '{rss_pkg::OP_ROTR, 1'b1, 7'h40, 8'h5a, 8'h11, 3'h0, 8'h00, 8'h11, 8'h2d, 3'h0},
        '{rss_pkg::OP_SUB, 1'b0, 7'h09, 8'h77, 8'h10, 3'h0, 8'h10, 8'h00, 8'h77, 3'h7},
        '{rss_pkg::OP_SUB, 1'b0, 7'h09, 8'h77, 8'h01, 3'h7, 8'h00, 8'hff, 8'h77, 3'h0},
        '{rss_pkg::OP_SUB, 1'b0, 7'h09, 8'h77, 8'h00, 3'h4, 8'hff, 8'hff, 8'h77, 3'h3},
        '{rss_pkg::OP_SUB, 1'b0, 7'h09, 8'h77, 8'h0f, 3'h0, 8'h30, 8'h21, 8'h77, 3'h1},
        '{rss_pkg::OP_SUB, 1'b0, 7'h09, 8'h77, 8'h80, 3'h0, 8'h05, 8'h85, 8'h77, 3'h2}
    };

    // Device under test, watchdog ticking every 256 cycles
    rss_exec_unit #(.PRESCALE(16'h0100)) i_rss_exec_unit (
        .clock(clock), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sleeping(sleeping), .oscRun(oscRun)
    );

    // Clock
    always #2 clock = ~clock;

    // Hang guard
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT)
        begin
            errorCnt++;
            $display("wrong value at %0t: run timed out", $time);
            conclude();
        end
    end

    // ****************************************
    // Bus tasks and helpers
    // ****************************************
    // Write: address and data offered together, response awaited
    task automatic axiWr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
        begin
            @(posedge clock);
            s_axi_awaddr <= a;
            s_axi_wdata <= v;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            @(posedge clock);
            while (s_axi_awready !== 1'b1) @(posedge clock);
            chk({31'h0, s_axi_wready}, 32'h1, "wready with awready");
            s_axi_awvalid <= 1'b0;
            s_axi_wvalid <= 1'b0;
            @(posedge clock);
            while (s_axi_bvalid !== 1'b1) @(posedge clock);
            rs = s_axi_bresp;
            s_axi_bready <= 1'b0;
        end
    endtask

    // Read: data and response taken at the rvalid edge
    task automatic axiRd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        begin
            @(posedge clock);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            @(posedge clock);
            while (s_axi_arready !== 1'b1) @(posedge clock);
            s_axi_arvalid <= 1'b0;
            @(posedge clock);
            while (s_axi_rvalid !== 1'b1) @(posedge clock);
            v = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        begin
            checksDone++;
            if (got !== exp)
            begin
                errorCnt++;
                $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
            end
        end
    endtask

    // Accesses that must answer OKAY
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [1:0] rs;
        begin
            axiWr(a, v, rs);
            chk({30'h0, rs}, {30'h0, rss_pkg::RESP_OKAY}, "write response");
        end
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        logic [1:0] rs;
        begin
            axiRd(a, v, rs);
            chk({30'h0, rs}, {30'h0, rss_pkg::RESP_OKAY}, "read response");
        end
    endtask

    function automatic logic [31:0] mkCmd(input logic [2:0] op, input logic dst,
                                          input logic [6:0] fa, input logic [7:0] lit);
        logic [31:0] c;
        begin
            c = 32'h0;
            c[rss_pkg::CMD_OP_LSB +: 3] = op;
            c[rss_pkg::CMD_DEST_BIT] = dst;
            c[rss_pkg::CMD_ADDR_LSB +: 7] = fa;
            c[rss_pkg::CMD_LIT_LSB +: 8] = lit;
            return c;
        end
    endfunction

    function automatic logic [11:0] fileAddr(input logic [6:0] fa);
        return {rss_pkg::FILE_REGION, fa, 2'b00};
    endfunction

    // Verdict
    task automatic conclude();
        begin
            $display("checks %0d mismatches %0d", checksDone, errorCnt);
            if (errorCnt == 0 && checksDone > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        // Values after reset
        rd(rss_pkg::ACC_OFS, d);
        chk(d, 32'h0, "acc after reset");
        rd(rss_pkg::STAT_OFS, d);
        chk(d, 32'h18, "status after reset");
        chk({30'h0, sleeping, oscRun}, 32'h1, "power pins after reset");
        $display("test reset done");
        // Table of rotates and subtracts
        foreach (rows[i])
        begin
            r = rows[i];
            wr(fileAddr(r.fa), {24'h0, r.fileIn});
            wr(rss_pkg::ACC_OFS, {24'h0, r.accIn});
            wr(rss_pkg::STAT_OFS, {29'h0, r.flagIn});
            wr(rss_pkg::CMD_OFS, mkCmd(r.op, r.dest, r.fa, r.lit));
            rd(rss_pkg::ACC_OFS, d);
            chk(d, {24'h0, r.accOut}, "acc");
            rd(fileAddr(r.fa), d);
            chk(d, {24'h0, r.fileOut}, "file");
            rd(rss_pkg::STAT_OFS, d);
            chk(d & 32'h7, {29'h0, r.flagOut}, "flags");
        end
        $display("test table done");
        // Back-to-back rotates through carry, second waits for the first
        wr(fileAddr(7'h03), 32'h81);
        wr(rss_pkg::STAT_OFS, 32'h0);
        wr(rss_pkg::CMD_OFS, mkCmd(rss_pkg::OP_ROTL, 1'b1, 7'h03, 8'h00));
        wr(rss_pkg::CMD_OFS, mkCmd(rss_pkg::OP_ROTL, 1'b1, 7'h03, 8'h00));
        rd(fileAddr(7'h03), d);
        chk(d, 32'h05, "double rotate");
        rd(rss_pkg::STAT_OFS, d);
        chk(d & 32'h7, 32'h0, "double rotate carry");
        $display("test back to back done");
        // Unmapped address
        axiWr(12'h100, 32'h5a, resp);
        chk({30'h0, resp}, {30'h0, rss_pkg::RESP_SLVERR}, "unmapped write");
        axiRd(12'h100, d, resp);
        chk(d, 32'h0, "unmapped read data");
        chk({30'h0, resp}, {30'h0, rss_pkg::RESP_SLVERR}, "unmapped read");
        $display("test unmapped done");
        // Power-down with a running watchdog
        repeat (600) @(posedge clock);
        rd(rss_pkg::WDOG_OFS, d);
        chk({31'h0, d[7:0] != 8'h00}, 32'h1, "watchdog running");
        wr(rss_pkg::CMD_OFS, mkCmd(rss_pkg::OP_SLEEP, 1'b0, 7'h00, 8'h00));
        rd(rss_pkg::STAT_OFS, d);
        chk({30'h0, d[4:3]}, 32'h2, "expiry and power-down");
        chk({31'h0, d[6]}, 32'h1, "sleep status");
        rd(rss_pkg::WDOG_OFS, d);
        chk(d, {24'h0, rss_pkg::WDOG_CLEAR}, "watchdog cleared");
        chk({30'h0, sleeping, oscRun}, 32'h2, "asleep, oscillator halted");
        // A command while asleep is latched but not executed
        wr(rss_pkg::CMD_OFS, mkCmd(rss_pkg::OP_SUB, 1'b0, 7'h00, 8'h00));
        rd(rss_pkg::ACC_OFS, d);
        chk(d, {24'h0, rows[8].accOut}, "no subtract while asleep");
        // A cleared prescaler keeps the count at zero for most of a tick
        repeat (200) @(posedge clock);
        rd(rss_pkg::WDOG_OFS, d);
        chk(d, 32'h0, "prescaler cleared");
        wr(rss_pkg::CMD_OFS, mkCmd(rss_pkg::OP_WAKE, 1'b0, 7'h00, 8'h00));
        rd(rss_pkg::STAT_OFS, d);
        chk({31'h0, d[3]}, 32'h0, "power-down stays clear");
        chk({30'h0, sleeping, oscRun}, 32'h1, "awake");
        // An unused op code leaves the accumulator alone
        wr(rss_pkg::CMD_OFS, mkCmd(3'h7, 1'b0, 7'h00, 8'h00));
        rd(rss_pkg::ACC_OFS, d);
        chk(d, {24'h0, rows[8].accOut}, "unused op code");
        $display("test sleep done");
        // Reset in mid-run restores the handshakes, power pins, accumulator and status, power-down included
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        chk({28'h0, s_axi_awready, s_axi_bvalid, s_axi_arready, s_axi_rvalid}, 32'h0, "idle");
        chk({30'h0, sleeping, oscRun}, 32'h1, "power pins in reset");
        rd(rss_pkg::ACC_OFS, d);
        chk(d, {24'h0, rss_pkg::ACC_RESET}, "acc after mid-run reset");
        rd(rss_pkg::STAT_OFS, d);
        chk(d, 32'h18, "status after mid-run reset");
        $display("test mid-run reset done");
        conclude();
    end
endmodule // tb

`default_nettype wire
